// *** shared/mcu_bus_port_map.svh ***
// Constants for the microcontroller bus port block and its bus controller.
// Notes on behaviour
// - Multiplexed bus: address byte caught on latch strobe.
// - Fetch, read and write strobes select accesses.
// - Fetch-only on input one, or read/fetch split.
// - Non-page host strobes address each command, once per burst.
// - Page hit keeps upper byte, decodes new low.
// - Burst host keeps A3-A0 apart, multiplexes A11-A4.
// - Burst holds upper address while low nibble steps.
// - Phase-enable mode with read/write select line.
// - Four ports: three eight-bit, one three-bit.
// - Configuration from stored setup or host writes.
// - Output mux: data, address, macrocell, external select.
// - Readback buffer drives one source at a time.
// - Driver enable is direction OR logic enable.
// - Input cells latch, register or pass through.
// - Stored-configuration modes fixed, others host-changeable.
// - An assigned pin serves no other function.
// - Shared port driven only on selected read.
// - Control bit zero gives host I/O mode.
// - Address out needs control and direction set.
`ifndef MCU_BUS_PORT_MAP_SVH
`define MCU_BUS_PORT_MAP_SVH
// Device register space: upper address byte and register index in the low bits.
`define IO_PAGE 8'hf0
`define REG_DATA_IN 3'h0
`define REG_CELL 3'h1
`define REG_CTRL 3'h2
`define REG_MC 3'h3
`define REG_DATA_OUT 3'h4
`define REG_DIR 3'h6
`define DOUT_RESET 8'h00
`define DIR_RESET 8'h00
`define CTRL_RESET 8'h00
`define PIN_COUNT 27
// Controller registers on the AXI4-Lite side.
`define H_CONFIG 8'h00
`define H_ADDR 8'h04
`define H_WDATA 8'h08
`define H_CMD 8'h0c
`define H_STATUS 8'h10
`define H_RDATA 8'h14
`define CFG_FETCH_ONLY 2
`define CMD_COUNT_LSB 4
`define ST_BUSY 0
`define ST_DONE 1
// Bus timing.
`define CLK_PERIOD_NS 5
`define LATCH_NS 10
`define LATCH_CYC ((`LATCH_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define STROBE_NS 20
`define STROBE_CYC ((`STROBE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// *** shared/mcu_bus_pkg.sv ***
// Types shared by the port block, its controller and the testbench.
package mcu_bus_pkg;
   typedef enum logic [1:0] {mode_mux_low, mode_page, mode_burst, mode_phase} bus_mode_e;
   typedef enum logic [1:0] {cell_direct, cell_latch, cell_reg} cell_mode_e;
   typedef enum logic [1:0] {kind_read, kind_write, kind_fetch} cmd_kind_e;
endpackage : mcu_bus_pkg

// *** shared/mcu_bus_if.sv ***
// Eight-bit microcontroller bus between the controller and the port block.
`timescale 1ns/1ps
interface mcu_bus_if;
   // Shared address/data lines, each end with its own drive and enable.
   logic [7:0] ad_host;
   logic ad_host_oe_n;
   logic [7:0] ad_dev;
   logic ad_dev_oe_n;
   // Unmultiplexed address lines.
   logic [7:0] addr_side;
   logic [3:0] addr_nib;
   // Strobes.
   logic address_latch_strobe;
   logic control_input_zero;
   logic control_input_one;
   logic control_input_two;
   // Resolved level of the shared lines.
   wire [7:0] shared_addr_data_port = !ad_dev_oe_n ? ad_dev : ad_host;

   modport host (
      output ad_host, ad_host_oe_n, addr_side, addr_nib, address_latch_strobe,
      output control_input_zero, control_input_one, control_input_two,
      input ad_dev, ad_dev_oe_n, shared_addr_data_port
   );
   modport dev (
      input ad_host, ad_host_oe_n, addr_side, addr_nib, address_latch_strobe,
      input control_input_zero, control_input_one, control_input_two,
      output ad_dev, ad_dev_oe_n
   );
endinterface : mcu_bus_if

// *** verilog/port_pin_cell.sv ***
// One port: output selection, driver enable, pin synchroniser and input cells.
`timescale 1ns/1ps
module port_pin_cell #(
   parameter int W = 8
) (
   // Clock and reset.
   input wire logic aclk,
   input wire logic aresetn,
   // Port registers and latched address.
   input wire logic [W-1:0] data_out,
   input wire logic [W-1:0] dir,
   input wire logic [W-1:0] ctrl,
   input wire logic [W-1:0] addr_byte,
   // Logic array terms and stored configuration.
   input wire logic [W-1:0] mc_out,
   input wire logic [W-1:0] mc_oe_term,
   input wire logic [W-1:0] oe_term_def,
   input wire logic [W-1:0] logic_pin,
   input wire logic [W-1:0] ext_pin,
   input wire logic [W-1:0] ext_val,
   input wire mcu_bus_pkg::cell_mode_e cell_mode,
   input wire logic [1:0] cell_en,
   // Pins.
   input wire logic [W-1:0] pin_in,
   output logic [W-1:0] pin_out,
   output logic [W-1:0] pin_oe_n,
   output logic [W-1:0] pin_sync,
   output logic [W-1:0] cell_out
);
   import mcu_bus_pkg::*;

   logic [W-1:0] meta;
   logic [1:0] en_prev;
   logic [W-1:0] en_bit;
   logic [W-1:0] en_rise;

   // A logic-owned pin ignores the host control bit, so it cannot be taken over.
   wire [W-1:0] host_pin = ~logic_pin & ~ext_pin;
   wire [W-1:0] next_pin_out = (logic_pin & mc_out)
      | (~logic_pin & ext_pin & ext_val)
      | (host_pin & ctrl & addr_byte)
      | (host_pin & ~ctrl & data_out);
   wire [W-1:0] next_oe = dir | (mc_oe_term & oe_term_def);

   // Each enable serves one nibble of the port.
   for (genvar i = 0; i < W; i++) begin : g_en
      assign en_bit[i] = cell_en[i / 4];
      assign en_rise[i] = cell_en[i / 4] & ~en_prev[i / 4];
   end

   wire [W-1:0] cell_take = (cell_mode == cell_direct) ? '1 :
      (cell_mode == cell_latch) ? en_bit : en_rise;
   wire [W-1:0] next_cell = (cell_take & pin_sync) | (~cell_take & cell_out);

   // Pins come from outside the clock domain, so two flops precede any reader.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         meta <= '0;
         pin_sync <= '0;
         cell_out <= '0;
         en_prev <= 2'h0;
         pin_out <= '0;
         pin_oe_n <= '1;
      end else begin
         meta <= pin_in;
         pin_sync <= meta;
         cell_out <= next_cell;
         en_prev <= cell_en;
         pin_out <= next_pin_out;
         pin_oe_n <= ~next_oe;
      end
   end
endmodule : port_pin_cell

// *** verilog/mcu_bus_port_dev.sv ***
// Programmable I/O port block with microcontroller bus address capture.
`timescale 1ns/1ps
`include "mcu_bus_port_map.svh"
module mcu_bus_port_dev (
   // Clock and reset.
   input wire logic aclk,
   input wire logic aresetn,
   // Microcontroller bus.
   mcu_bus_if.dev bus,
   // Stored configuration, fixed while running.
   input wire mcu_bus_pkg::bus_mode_e cfg_bus_mode,
   input wire logic cfg_fetch_only,
   input wire logic cfg_addr_b_high,
   input wire logic [`PIN_COUNT-1:0] cfg_logic,
   input wire logic [`PIN_COUNT-1:0] cfg_oe_def,
   input wire logic [2:0] cfg_ext,
   input wire mcu_bus_pkg::cell_mode_e [2:0] cfg_cell_mode,
   input wire logic [2:0] cfg_cell_by_term,
   // Logic array terms.
   input wire logic [`PIN_COUNT-1:0] mc_out,
   input wire logic [`PIN_COUNT-1:0] mc_oe_term,
   input wire logic [2:0] external_select_outputs,
   input wire logic [5:0] cell_term,
   output logic [23:0] cell_out,
   // Internal memory port.
   output logic [15:0] mem_addr,
   output logic mem_rd,
   output logic mem_wr,
   output logic [7:0] mem_wdata,
   input wire logic [7:0] mem_rdata,
   // Port pins, port A in the low bits, port D in the top three.
   input wire logic [`PIN_COUNT-1:0] pin_in,
   output logic [`PIN_COUNT-1:0] pin_out,
   output logic [`PIN_COUNT-1:0] pin_oe_n
);
   import mcu_bus_pkg::*;

   // Port D is three pins wide; its upper register bits always read zero.
   function automatic logic [7:0] width_mask(input logic [1:0] p);
      return (p == 2'h3) ? 8'h07 : 8'hff;
   endfunction : width_mask

   logic [7:0] lat;
   logic wr_seen;
   logic [3:0][7:0] data_out;
   logic [3:0][7:0] dir;
   logic [1:0][7:0] ctrl;
   logic [31:0] sync_all;
   logic [31:0] cell_all;
   logic [3:0][7:0] ctrl_eff;
   logic [3:0][7:0] addr_byte;

   // Strobe decode for the strobe styles a host may use.
   wire phase = (cfg_bus_mode == mode_phase);
   wire fetch_on = cfg_fetch_only ? ~bus.control_input_one
      : (~phase & ~bus.control_input_two);
   wire rd_on = phase ? (bus.control_input_one & bus.control_input_zero)
      : (~cfg_fetch_only & ~bus.control_input_one);
   wire wr_on = phase ? (bus.control_input_one & ~bus.control_input_zero)
      : ~bus.control_input_zero;

   // The latched byte joins the live lines according to the bus style.
   wire [15:0] cur_addr = (cfg_bus_mode == mode_page) ? {lat, bus.addr_side}
      : (cfg_bus_mode == mode_burst) ? {bus.addr_side[3:0], lat, bus.addr_nib}
      : {bus.addr_side, lat};

   // Register space decode.
   wire io_hit = (cur_addr[15:8] == `IO_PAGE) && (cur_addr[7:5] == 3'h0);
   wire [1:0] port_sel = cur_addr[4:3];
   wire [2:0] reg_sel = cur_addr[2:0];
   wire [4:0] byte_idx = {port_sel, 3'h0};
   wire io_rd = rd_on & io_hit;
   wire mem_rd_on = (rd_on & ~io_hit) | fetch_on;
   wire wr_edge = wr_on & ~wr_seen;
   wire io_wr = wr_edge & io_hit;
   wire [7:0] wdata = bus.ad_host & width_mask(port_sel);

   // Readback buffer: at most one source per register index.
   wire [31:0] mc_all = {5'h00, mc_out};
   wire [7:0] ctrl_rd = port_sel[1] ? 8'h00 : ctrl[port_sel[0]];
   wire [7:0] readback = (reg_sel == `REG_DATA_IN) ? sync_all[byte_idx +: 8]
      : (reg_sel == `REG_CELL) ? cell_all[byte_idx +: 8]
      : (reg_sel == `REG_CTRL) ? ctrl_rd
      : (reg_sel == `REG_MC) ? mc_all[byte_idx +: 8]
      : (reg_sel == `REG_DATA_OUT) ? data_out[port_sel]
      : (reg_sel == `REG_DIR) ? dir[port_sel]
      : 8'h00;

   // Address capture. The byte holds until the next strobe, which keeps a page
   // hit or a burst on the old upper address without another strobe.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         lat <= 8'h00;
      end else if (bus.address_latch_strobe) begin
         lat <= bus.ad_host;
      end
   end

   // Shared lines are driven only for a selected read, one cycle behind.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bus.ad_dev <= 8'h00;
         bus.ad_dev_oe_n <= 1'b1;
      end else begin
         bus.ad_dev <= io_rd ? readback : mem_rdata;
         bus.ad_dev_oe_n <= ~(io_rd | mem_rd_on);
      end
   end

   // Memory port follows the decoded address each cycle.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mem_addr <= 16'h0000;
         mem_rd <= 1'b0;
         mem_wr <= 1'b0;
         mem_wdata <= 8'h00;
         wr_seen <= 1'b0;
      end else begin
         mem_addr <= cur_addr;
         mem_rd <= mem_rd_on;
         mem_wr <= wr_edge & ~io_hit;
         mem_wdata <= bus.ad_host;
         wr_seen <= wr_on;
      end
   end

   // Host writes to the port registers take effect once per write strobe.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         data_out <= {4{`DOUT_RESET}};
         dir <= {4{`DIR_RESET}};
         ctrl <= {2{`CTRL_RESET}};
      end else if (io_wr) begin
         if (reg_sel == `REG_DATA_OUT) begin
            data_out[port_sel] <= wdata;
         end
         if (reg_sel == `REG_DIR) begin
            dir[port_sel] <= wdata;
         end
         if (reg_sel == `REG_CTRL && !port_sel[1]) begin
            ctrl[port_sel[0]] <= wdata;
         end
      end
   end

   // Only ports A and B have control bits; B may carry the upper byte.
   assign ctrl_eff = {16'h0000, ctrl};
   assign addr_byte[0] = cur_addr[7:0];
   assign addr_byte[1] = cfg_addr_b_high ? cur_addr[15:8] : cur_addr[7:0];
   assign addr_byte[2] = 8'h00;
   assign addr_byte[3] = 8'h00;
   assign sync_all[31:`PIN_COUNT] = 5'h00;
   assign cell_all[31:`PIN_COUNT] = 5'h00;
   assign cell_out = cell_all[23:0];

   // One cell per port; port D has external selects and no input cells.
   for (genvar p = 0; p < 4; p++) begin : g_port
      localparam int W = (p == 3) ? 3 : 8;
      localparam int B = p * 8;
      wire [1:0] en = (p == 3) ? 2'h0 : cfg_cell_by_term[p % 3]
         ? cell_term[2 * (p % 3) +: 2] : {2{bus.address_latch_strobe}};
      wire [W-1:0] ext_pin = (p == 3) ? W'(cfg_ext) : '0;
      wire [W-1:0] ext_val = (p == 3) ? W'(external_select_outputs) : '0;
      port_pin_cell #(.W(W)) u_cell (
         .aclk(aclk),
         .aresetn(aresetn),
         .data_out(data_out[p][W-1:0]),
         .dir(dir[p][W-1:0]),
         .ctrl(ctrl_eff[p][W-1:0]),
         .addr_byte(addr_byte[p][W-1:0]),
         .mc_out(mc_out[B +: W]),
         .mc_oe_term(mc_oe_term[B +: W]),
         .oe_term_def(cfg_oe_def[B +: W]),
         .logic_pin(cfg_logic[B +: W]),
         .ext_pin(ext_pin),
         .ext_val(ext_val),
         .cell_mode((p == 3) ? cell_direct : cfg_cell_mode[p % 3]),
         .cell_en(en),
         .pin_in(pin_in[B +: W]),
         .pin_out(pin_out[B +: W]),
         .pin_oe_n(pin_oe_n[B +: W]),
         .pin_sync(sync_all[B +: W]),
         .cell_out(cell_all[B +: W])
      );
   end
endmodule : mcu_bus_port_dev

// *** verilog/mcu_bus_host.sv ***
// Bus controller: runs microcontroller bus cycles ordered over AXI4-Lite.
//
// The placing of the registers and the AXI4-Lite register port are this design's own decisions.
`timescale 1ns/1ps
`include "mcu_bus_port_map.svh"
module mcu_bus_host (
   // Clock and reset.
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite slave.
   input wire logic [7:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [7:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   // Microcontroller bus.
   mcu_bus_if.host bus
);
   import mcu_bus_pkg::*;

   typedef enum logic [2:0] {st_idle, st_latch, st_hold, st_strobe, st_gap} state_e;
   state_e state;
   bus_mode_e mode;
   cmd_kind_e kind;
   logic fetch_only;
   logic [15:0] addr;
   logic [7:0] wbyte;
   logic [31:0] rd_shift;
   logic busy;
   logic done;
   logic [3:0] beats;
   logic [3:0] cnt;
   logic [7:0] last_hi;
   logic page_ok;

   // Write decode; address and data are taken together in one cycle.
   wire w_take = awready;
   wire w_cfg = w_take && awaddr == `H_CONFIG && wstrb[0];
   wire start = w_take && awaddr == `H_CMD && wstrb[0] && !busy;
   wire w_map = awaddr == `H_CONFIG || awaddr == `H_ADDR || awaddr == `H_WDATA
      || awaddr == `H_CMD;
   wire page_hit = mode == mode_page && page_ok && addr[15:8] == last_hi;
   wire [7:0] mux_byte = (mode == mode_page) ? addr[15:8]
      : (mode == mode_burst) ? addr[11:4] : addr[7:0];
   wire [7:0] side_byte = (mode == mode_page) ? addr[7:0]
      : (mode == mode_burst) ? {4'h0, addr[15:12]} : addr[15:8];
   wire strobing = state == st_strobe;
   wire writing = kind == kind_write;
   wire [31:0] rd_mux = (araddr == `H_CONFIG) ? {29'h0, fetch_only, mode}
      : (araddr == `H_ADDR) ? {16'h0000, addr}
      : (araddr == `H_WDATA) ? {24'h000000, wbyte}
      : (araddr == `H_STATUS) ? {30'h0, done, busy}
      : (araddr == `H_RDATA) ? rd_shift : 32'h0;
   wire r_map = araddr == `H_CONFIG || araddr == `H_ADDR || araddr == `H_WDATA
      || araddr == `H_STATUS || araddr == `H_RDATA;

   // AXI4-Lite handshakes; one write and one read at a time.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready <= 1'b0;
         wready <= 1'b0;
         bvalid <= 1'b0;
         bresp <= 2'h0;
         arready <= 1'b0;
         rvalid <= 1'b0;
         rresp <= 2'h0;
         rdata <= 32'h0;
      end else begin
         awready <= awvalid && wvalid && !awready && !bvalid;
         wready <= awvalid && wvalid && !awready && !bvalid;
         if (w_take) begin
            bvalid <= 1'b1;
            bresp <= w_map ? 2'h0 : 2'h2;
         end else if (bready) begin
            bvalid <= 1'b0;
         end
         arready <= arvalid && !arready && !rvalid;
         if (arready) begin
            rvalid <= 1'b1;
            rdata <= rd_mux;
            rresp <= r_map ? 2'h0 : 2'h2;
         end else if (rready) begin
            rvalid <= 1'b0;
         end
      end
   end

   // Command sequencer: address phase, hold, strobe, gap.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state <= st_idle;
         mode <= mode_mux_low;
         kind <= kind_read;
         fetch_only <= 1'b0;
         addr <= 16'h0000;
         wbyte <= 8'h00;
         rd_shift <= 32'h0;
         busy <= 1'b0;
         done <= 1'b0;
         beats <= 4'h0;
         cnt <= 4'h0;
         last_hi <= 8'h00;
         page_ok <= 1'b0;
      end else begin
         if (w_cfg && !busy) begin
            mode <= bus_mode_e'(wdata[1:0]);
            fetch_only <= wdata[`CFG_FETCH_ONLY];
            page_ok <= 1'b0;
         end
         if (w_take && awaddr == `H_ADDR && !busy) begin
            if (wstrb[0]) addr[7:0] <= wdata[7:0];
            if (wstrb[1]) addr[15:8] <= wdata[15:8];
         end
         if (w_take && awaddr == `H_WDATA && wstrb[0] && !busy) begin
            wbyte <= wdata[7:0];
         end
         unique case (state)
            st_idle: if (start) begin
               kind <= cmd_kind_e'(wdata[1:0]);
               beats <= (mode == mode_burst && wdata[1:0] == 2'h2)
                  ? wdata[`CMD_COUNT_LSB +: 4] : 4'h0;
               busy <= 1'b1;
               done <= 1'b0;
               cnt <= 4'((page_hit ? `STROBE_CYC : `LATCH_CYC) - 1);
               state <= page_hit ? st_strobe : st_latch;
            end
            st_latch: if (cnt == 4'h0) begin
               last_hi <= addr[15:8];
               page_ok <= (mode == mode_page);
               state <= st_hold;
            end else begin
               cnt <= cnt - 4'h1;
            end
            st_hold: begin
               cnt <= 4'(`STROBE_CYC - 1);
               state <= st_strobe;
            end
            st_strobe: if (cnt == 4'h0) begin
               state <= st_gap;
            end else begin
               cnt <= cnt - 4'h1;
            end
            st_gap: begin
               if (!writing) rd_shift <= {rd_shift[23:0], bus.shared_addr_data_port};
               if (beats != 4'h0) begin
                  beats <= beats - 4'h1;
                  addr[3:0] <= addr[3:0] + 4'h1;
                  cnt <= 4'(`STROBE_CYC - 1);
                  state <= st_strobe;
               end else begin
                  busy <= 1'b0;
                  done <= 1'b1;
                  state <= st_idle;
               end
            end
         endcase
      end
   end

   // Bus pins follow the sequencer state one cycle later.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bus.ad_host <= 8'h00;
         bus.ad_host_oe_n <= 1'b1;
         bus.addr_side <= 8'h00;
         bus.addr_nib <= 4'h0;
         bus.address_latch_strobe <= 1'b0;
         bus.control_input_zero <= 1'b1;
         bus.control_input_one <= 1'b1;
         bus.control_input_two <= 1'b1;
      end else begin
         bus.ad_host <= strobing ? wbyte : mux_byte;
         bus.ad_host_oe_n <= !(state == st_latch || state == st_hold
            || (strobing && writing));
         bus.addr_side <= side_byte;
         bus.addr_nib <= addr[3:0];
         bus.address_latch_strobe <= state == st_latch;
         if (mode == mode_phase) begin
            bus.control_input_zero <= !writing;
            bus.control_input_one <= strobing;
            bus.control_input_two <= 1'b1;
         end else begin
            bus.control_input_zero <= !(strobing && writing);
            bus.control_input_one <= !(strobing && (kind == kind_read
               || (kind == kind_fetch && fetch_only)));
            bus.control_input_two <= !(strobing && kind == kind_fetch && !fetch_only);
         end
      end
   end
endmodule : mcu_bus_host

// *** test/mcu_bus_port_block_properties.sv ***
// Bus-level properties for the controller and port block across the shared bus.
`timescale 1ns/1ps
module mcu_bus_port_properties (
   // Clock and reset.
   input wire logic aclk,
   input wire logic aresetn,
   // Shared lines and address lines.
   input wire logic [7:0] ad_host,
   input wire logic ad_host_oe_n,
   input wire logic [7:0] ad_dev,
   input wire logic ad_dev_oe_n,
   input wire logic [7:0] addr_side,
   input wire logic [3:0] addr_nib,
   // Strobes.
   input wire logic address_latch_strobe,
   input wire logic control_input_zero,
   input wire logic control_input_one,
   input wire logic control_input_two
);
   // One clock domain, so clocking and reset are given once.
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   // Any strobe active, used to find the hold cycle after the latch strobe.
   wire any_strobe = !(control_input_zero && control_input_one && control_input_two);
   chk_dev_read_only: assert property (!ad_dev_oe_n
      |-> !$past(control_input_one) || !$past(control_input_two))
      else $error("Device drove the shared lines outside a read.");
   chk_no_contention: assert property (!ad_dev_oe_n |-> ad_host_oe_n)
      else $error("Both ends drove the shared lines.");
   chk_strobe_len: assert property ($fell(control_input_one)
      |-> !control_input_one [*4] ##1 control_input_one)
      else $error("Read strobe did not last four cycles.");
   chk_latch_len: assert property ($rose(address_latch_strobe)
      |-> address_latch_strobe [*2] ##1 !address_latch_strobe)
      else $error("Latch strobe did not last two cycles.");
   chk_latch_drive: assert property (address_latch_strobe |-> !ad_host_oe_n)
      else $error("Latch strobe without the address on the shared lines.");
   chk_write_drive: assert property (!control_input_zero |-> !ad_host_oe_n && ad_dev_oe_n)
      else $error("Write strobe without host data on the shared lines.");
   chk_one_strobe: assert property (
      $onehot0({!control_input_zero, !control_input_one, !control_input_two}))
      else $error("Two strobes active together.");
   chk_hold_gap: assert property ($fell(address_latch_strobe) |-> !any_strobe ##1 any_strobe)
      else $error("No single hold cycle between latch and strobe.");
   chk_upper_held: assert property ((!control_input_one && !$past(control_input_one))
      || (!control_input_two && !$past(control_input_two))
      |-> $stable(addr_side) && $stable(addr_nib))
      else $error("Address lines moved inside a strobe.");
endmodule : mcu_bus_port_properties

// *** test/mcu_bus_port_block_bench.sv ***
// Testbench: orders bus cycles over AXI4-Lite and checks the port block's answers.
`timescale 1ns/1ps
`include "mcu_bus_port_map.svh"
module mcu_bus_port_block_bench;
   import mcu_bus_pkg::*;
   logic aclk = 0;
   logic aresetn = 0;
   logic [7:0] awaddr = '0, araddr = '0;
   logic [31:0] wdata = '0;
   logic [3:0] wstrb = '0;
   logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp, rs;
   logic [31:0] rdata, rd;
   bus_mode_e cfg_bus_mode = mode_mux_low;
   logic cfg_fetch_only = 0, cfg_addr_b_high = 0;
   logic [26:0] mc_oe_term = '0, pin_out, pin_oe_n, mc_out = '0, cfg_logic = '0;
   logic [26:0] pin_in = 27'h03c0000, cfg_oe_def = 27'h1000000;
   logic [15:0] mem_addr;
   logic [7:0] mem_rdata;
   int err_total = 0, num_checks = 0, cyc = 0;
   // Memory pattern depends on both address bytes, so a wrong upper byte shows.
   function automatic logic [7:0] mem_val(input logic [15:0] a);
      return a[7:0] ^ a[15:8];
   endfunction : mem_val
   assign mem_rdata = mem_val(mem_addr);
   mcu_bus_if bus ();
   mcu_bus_host mcu_bus_host_inst (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata,
      .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready,
      .rdata, .rresp, .rvalid, .rready, .bus(bus));
   // Straps other than mode and fetch-only stay fixed; logic-array pins are left unused here.
   mcu_bus_port_dev mcu_bus_port_dev_inst (.aclk, .aresetn, .bus(bus), .cfg_bus_mode,
      .cfg_fetch_only, .cfg_addr_b_high, .cfg_logic, .cfg_oe_def, .mc_out,
      .cfg_ext(3'h0), .cfg_cell_mode('{3{cell_direct}}), .cfg_cell_by_term(3'h0), .mc_oe_term,
      .external_select_outputs(3'h0), .cell_term(6'h00), .cell_out(), .mem_addr, .mem_rd(),
      .mem_wr(), .mem_wdata(), .mem_rdata, .pin_in, .pin_out, .pin_oe_n);
   mcu_bus_port_properties mcu_bus_port_properties_inst (.aclk, .aresetn,
      .ad_host(bus.ad_host), .ad_host_oe_n(bus.ad_host_oe_n), .ad_dev(bus.ad_dev),
      .ad_dev_oe_n(bus.ad_dev_oe_n), .addr_side(bus.addr_side), .addr_nib(bus.addr_nib),
      .address_latch_strobe(bus.address_latch_strobe),
      .control_input_zero(bus.control_input_zero), .control_input_one(bus.control_input_one),
      .control_input_two(bus.control_input_two));
   // Clock at 200 MHz.
   always #2.5 aclk = ~aclk;
   // A hang counts as a mismatch; the tests need well under a thousand cycles.
   always @(posedge aclk) begin
      cyc++;
      if (cyc == 20000) begin
         err_total++;
         conclude();
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         err_total++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // Address and data are offered together and held until both are taken.
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      wstrb <= 4'hf;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      do @(posedge aclk); while ((awready & wready) !== 1'b1);
      awvalid <= 1'b0;
      wvalid <= 1'b0;
      bready <= 1'b1;
      do @(posedge aclk); while (bvalid !== 1'b1);
      rs = bresp;
      bready <= 1'b0;
   endtask : axi_wr
   task automatic axi_rd(input logic [7:0] a);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      do @(posedge aclk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      rready <= 1'b1;
      do @(posedge aclk); while (rvalid !== 1'b1);
      rd = rdata;
      rs = rresp;
      rready <= 1'b0;
   endtask : axi_rd
   // One bus operation; waits for done so no command is dropped as busy.
   task automatic op(input logic [15:0] a, input logic [7:0] d, input logic [7:0] cmd);
      axi_wr(`H_ADDR, {16'h0000, a});
      axi_wr(`H_WDATA, {24'h000000, d});
      axi_wr(`H_CMD, {24'h000000, cmd});
      do axi_rd(`H_STATUS); while (rd[`ST_DONE] !== 1'b1);
      axi_rd(`H_RDATA);
   endtask : op
   task automatic set_mode(input bus_mode_e m, input logic f);
      cfg_bus_mode <= m;
      cfg_fetch_only <= f;
      axi_wr(`H_CONFIG, {29'h00000000, f, m});
      chk({30'h0, rs}, 32'h0);
   endtask : set_mode
   task automatic conclude();
      $display("Checks %0d, mismatches %0d.", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : conclude
   // Main sequence.
   initial begin
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      chk({5'h00, pin_oe_n}, 32'h07ffffff);
      axi_rd(8'h20);
      chk({30'h0, rs}, 32'h2);
      $display("Test reset done.");
      op(16'hf006, 8'h5a, 8'h01);
      op(16'hf004, 8'h3c, 8'h01);
      op(16'hf006, 8'h00, 8'h00);
      chk(rd & 32'hff, 32'h5a);
      chk({24'h0, pin_oe_n[7:0]}, 32'ha5);
      chk({24'h0, pin_out[7:0] & 8'h5a}, 32'h18);
      op(16'hf010, 8'h00, 8'h00);
      chk(rd & 32'hff, 32'h3c);
      op(16'h1234, 8'h00, 8'h00);
      chk(rd & 32'hff, {24'h0, mem_val(16'h1234)});
      mc_oe_term <= 27'h1000000;
      repeat (2) @(posedge aclk);
      chk({31'h0, pin_oe_n[24]}, 32'h0);
      $display("Test multiplexed bus done.");
      set_mode(mode_page, 1'b0);
      op(16'hf004, 8'h00, 8'h00);
      op(16'hf006, 8'h00, 8'h00);
      chk(rd & 32'hffff, 32'h3c5a);
      $display("Test page mode done.");
      set_mode(mode_mux_low, 1'b1);
      op(16'hf006, 8'h00, 8'h02);
      chk(rd & 32'hff, {24'h0, mem_val(16'hf006)});
      set_mode(mode_mux_low, 1'b0);
      op(16'h0055, 8'h00, 8'h02);
      chk(rd & 32'hff, 32'h55);
      $display("Test fetch strobes done.");
      set_mode(mode_burst, 1'b0);
      op(16'h1230, 8'h00, 8'h32);
      chk(rd, {mem_val(16'h1230), mem_val(16'h1231), mem_val(16'h1232),
         mem_val(16'h1233)});
      $display("Test burst fetch done.");
      set_mode(mode_mux_low, 1'b0);
      op(16'hf002, 8'hff, 8'h01);
      op(16'hf006, 8'hff, 8'h01);
      op(16'h00a5, 8'h00, 8'h00);
      chk({24'h0, pin_out[7:0]}, 32'ha5);
      $display("Test address out done.");
      conclude();
   end
endmodule : mcu_bus_port_block_bench
